// *** hdl/icc_cfg.sv ***
// indirect configuration logic: pointer, byte count, own address, scl periods,
// scl-low time-out, software reset key, and the master scl period generator
// assumes an asynchronous parallel bus on pins, an oscillator clock for the scl generator,
// and a neighbouring engine that supplies master/start/address and buffered receive counts
`include "icc_defs.svh"

module icc_cfg #(
    parameter int unsigned P_TO_UNIT_CYC = int'($floor(`ICC_TO_UNIT_US * 1000.0 / `ICC_REF_PERIOD_NS))
) (
    // clocks and reset
    input wire logic i_ref_clk,
    input wire logic i_osc_clk,
    input wire logic i_rst,
    // parallel bus pins
    input wire logic i_cs_n,
    input wire logic i_wr_n,
    input wire logic i_rd_n,
    input wire logic [1:0] i_addr,
    input wire logic [7:0] i_data,
    output logic [7:0] o_data,
    output logic o_data_oe_n,
    output logic o_int_n,
    // scl pin
    input wire logic i_scl,
    output logic o_scl_out,
    output logic o_scl_oe_n,
    // serial engine side, same clock as the registers
    input wire logic i_master,
    input wire logic i_start_req,
    input wire logic i_addr_valid,
    input wire logic [7:0] i_addr_byte,
    input wire logic i_rx_count_we,
    input wire logic [6:0] i_rx_count,
    // configuration and events toward the serial engine
    output logic o_buffered_mode,
    output logic [6:0] o_byte_count,
    output logic o_last_byte_nack,
    output logic o_count_bad,
    output logic o_own_match,
    output logic o_gc_match,
    output logic o_bus_error,
    output logic o_soft_reset
);

    localparam int unsigned TO_UNIT_CYC = (P_TO_UNIT_CYC < 1) ? 1 : P_TO_UNIT_CYC;

    // register-side state
    typedef struct packed {
        icc_pkg::icc_pbus_s pin_m;    // first synchroniser stage
        icc_pkg::icc_pbus_s pin_s;    // second synchroniser stage
        icc_pkg::icc_pbus_s pin_d;    // previous sample, for edges
        logic scl_m;
        logic scl_s;
        logic scl_d;
        logic ack_m;
        logic ack_s;
        logic req;                    // handshake toggle toward oscillator side
        icc_pkg::icc_link_s hold;     // word held stable while a request is out
        logic [7:0] ptr;
        logic [7:0] count;
        logic [7:0] own_addr;
        logic [7:0] scl_low;
        logic [7:0] scl_high;
        logic [7:0] timeout;
        logic key_armed;
        logic mode;
        logic si;
        logic [7:0] status;
        logic bus_err;
        logic [31:0] pre;
        logic [6:0] units;
        logic [7:0] rdata;
        logic doe_n;
        logic int_n;
        logic count_bad;
        logic own_match;
        logic gc_match;
        logic soft_rst;
    } ref_s;

    // oscillator-side state
    typedef struct packed {
        logic req_m;
        logic req_s;
        logic ack;
        icc_pkg::icc_link_s cfg;
        icc_pkg::icc_scl_e state;
        logic [7:0] cnt;
        logic scl_oe_n;
    } osc_s;

    ref_s r_reg;
    ref_s r_next;
    osc_s o_reg;
    osc_s o_next;

    // power-up and software reset contents of the register side
    function automatic ref_s ref_reset();
        ref_s v;
        v = '0;
        v.pin_m = '1;
        v.pin_s = '1;
        v.pin_d = '1;
        v.scl_m = 1'b1;
        v.scl_s = 1'b1;
        v.scl_d = 1'b1;
        v.count = `ICC_RST_COUNT;
        v.own_addr = `ICC_RST_OWN_ADDR;
        v.scl_low = `ICC_RST_SCL_LOW;
        v.scl_high = `ICC_RST_SCL_HIGH;
        v.timeout = `ICC_RST_TIMEOUT;
        v.status = `ICC_RST_STATUS;
        v.doe_n = 1'b1;
        v.int_n = 1'b1;
        v.hold.low_period = `ICC_RST_SCL_LOW;
        v.hold.high_period = `ICC_RST_SCL_HIGH;
        return v;
    endfunction

    // read value of an indirect register, write-only key reads zero
    function automatic logic [7:0] ind_read(input ref_s s);
        if (s.ptr == `ICC_IND_COUNT) begin
            return s.count;
        end else if (s.ptr == `ICC_IND_OWN_ADDR) begin
            return s.own_addr;
        end else if (s.ptr == `ICC_IND_SCL_LOW) begin
            return s.scl_low;
        end else if (s.ptr == `ICC_IND_SCL_HIGH) begin
            return s.scl_high;
        end else if (s.ptr == `ICC_IND_TIMEOUT) begin
            return s.timeout;
        end else begin
            return 8'h00;
        end
    endfunction

    // register side: bus decode, key sequence, time-out, address compare, handshake
    always_comb begin
        logic wr_evt;
        logic rd_act;
        logic is_key;
        logic scl_fell;
        logic to_run;
        logic [7:0] wd;
        logic [6:0] bc;
        r_next = r_reg;
        wr_evt = 1'b0;
        rd_act = 1'b0;
        is_key = 1'b0;
        scl_fell = 1'b0;
        to_run = 1'b0;
        wd = r_reg.pin_d.data;
        bc = 7'h00;
        // synchronisers, first stage read only by the second
        r_next.pin_m = '{cs_n: i_cs_n, wr_n: i_wr_n, rd_n: i_rd_n, addr: i_addr, data: i_data};
        r_next.pin_s = r_reg.pin_m;
        r_next.pin_d = r_reg.pin_s;
        r_next.scl_m = i_scl;
        r_next.scl_s = r_reg.scl_m;
        r_next.scl_d = r_reg.scl_s;
        r_next.ack_m = o_reg.ack;
        r_next.ack_s = r_reg.ack_m;
        // single-cycle outputs drop by default
        r_next.count_bad = 1'b0;
        r_next.own_match = 1'b0;
        r_next.gc_match = 1'b0;
        r_next.soft_rst = 1'b0;
        // a write completes on the rising edge of the write strobe
        wr_evt = !r_reg.pin_d.wr_n && r_reg.pin_s.wr_n && !r_reg.pin_d.cs_n;
        rd_act = !r_reg.pin_s.cs_n && !r_reg.pin_s.rd_n;
        is_key = (r_reg.pin_d.addr == `ICC_DIR_INDIRECT) && (r_reg.ptr == `ICC_IND_RESET_KEY);
        // read data and bus drive; reads never touch the key sequence
        r_next.doe_n = !rd_act;
        if (r_reg.pin_s.addr == `ICC_DIR_PTR_STATUS) begin
            r_next.rdata = r_reg.status;
        end else if (r_reg.pin_s.addr == `ICC_DIR_INDIRECT) begin
            r_next.rdata = ind_read(r_reg);
        end else if (r_reg.pin_s.addr == `ICC_DIR_CONTROL) begin
            r_next.rdata = 8'h00;
            r_next.rdata[`ICC_MODE_BIT] = r_reg.mode;
            r_next.rdata[`ICC_SI_BIT] = r_reg.si;
        end else begin
            r_next.rdata = 8'h00;
        end
        // writes
        if (wr_evt) begin
            // any write other than a first key breaks the sequence
            r_next.key_armed = 1'b0;
            if (r_reg.pin_d.addr == `ICC_DIR_PTR_STATUS) begin
                r_next.ptr = wd;
            end else if (r_reg.pin_d.addr == `ICC_DIR_CONTROL) begin
                r_next.mode = wd[`ICC_MODE_BIT];
                r_next.si = 1'b0;
                bc = r_reg.count[6:0];
                if (wd[`ICC_MODE_BIT] && ((bc == 7'h00) || (bc > `ICC_MAX_COUNT))) begin
                    r_next.si = 1'b1;
                    r_next.count_bad = 1'b1;
                end
            end else if (is_key) begin
                if (r_reg.key_armed && (wd == `ICC_KEY_SECOND)) begin
                    r_next.soft_rst = 1'b1;
                end else begin
                    r_next.key_armed = (wd == `ICC_KEY_FIRST);
                end
            end else if (r_reg.pin_d.addr == `ICC_DIR_INDIRECT) begin
                if (r_reg.ptr == `ICC_IND_COUNT) begin
                    r_next.count = wd;
                end else if (r_reg.ptr == `ICC_IND_OWN_ADDR) begin
                    r_next.own_addr = wd;
                end else if (r_reg.ptr == `ICC_IND_SCL_LOW) begin
                    r_next.scl_low = wd;
                end else if (r_reg.ptr == `ICC_IND_SCL_HIGH) begin
                    r_next.scl_high = wd;
                end else if (r_reg.ptr == `ICC_IND_TIMEOUT) begin
                    r_next.timeout = wd;
                end
            end
        end
        // received count from the buffer engine wins over a host write
        if (i_rx_count_we) begin
            r_next.count[6:0] = i_rx_count;
        end
        // slave address compare, ignored as master
        if (i_addr_valid && !i_master) begin
            r_next.own_match = (i_addr_byte[7:1] == r_reg.own_addr[7:1]);
            r_next.gc_match = r_reg.own_addr[`ICC_GC_BIT] && (i_addr_byte[7:1] == 7'h00);
        end
        // scl-low time-out: runs while enabled, scl low and a master action pending
        scl_fell = r_reg.scl_d && !r_reg.scl_s;
        to_run = r_reg.timeout[`ICC_TE_BIT] && !r_reg.scl_s && (i_master || i_start_req) && !r_reg.bus_err;
        if (!to_run || scl_fell) begin
            r_next.pre = 32'h0;
            r_next.units = 7'h00;
        end else if (r_reg.pre == 32'(TO_UNIT_CYC - 1)) begin
            r_next.pre = 32'h0;
            if (r_reg.units == r_reg.timeout[6:0]) begin
                r_next.bus_err = 1'b1;
                r_next.status = `ICC_STATUS_BUS_ERROR;
                r_next.si = 1'b1;
            end else begin
                r_next.units = r_reg.units + 7'h01;
            end
        end else begin
            r_next.pre = r_reg.pre + 32'h1;
        end
        // handshake: send a fresh word once the last one is acknowledged
        if (r_reg.ack_s == r_reg.req) begin
            r_next.hold.low_period = r_reg.scl_low;
            r_next.hold.high_period = r_reg.scl_high;
            r_next.hold.run = i_master && !r_reg.bus_err;
            r_next.hold.stretch = r_reg.si;
            r_next.req = !r_reg.req;
        end
        r_next.int_n = !r_next.si;
        // software reset restores everything but the crossing logic
        if (r_reg.soft_rst) begin
            r_next = ref_reset();
            r_next.pin_m = r_reg.pin_m;
            r_next.pin_s = r_reg.pin_s;
            r_next.pin_d = r_reg.pin_d;
            r_next.scl_m = r_reg.scl_m;
            r_next.scl_s = r_reg.scl_s;
            r_next.scl_d = r_reg.scl_d;
            r_next.ack_m = r_reg.ack_m;
            r_next.ack_s = r_reg.ack_s;
            r_next.req = r_reg.req;
            r_next.hold = r_reg.hold;
        end
    end

    // register-side flip-flops
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            r_reg <= ref_reset();
        end else begin
            r_reg <= r_next;
        end
    end

    // oscillator side: take handed word, then generate master scl low and high periods
    always_comb begin
        o_next = o_reg;
        o_next.req_m = r_reg.req;
        o_next.req_s = o_reg.req_m;
        // capture the word when a new request arrives
        if (o_reg.req_s != o_reg.ack) begin
            o_next.cfg = r_reg.hold;
            o_next.ack = o_reg.req_s;
        end
        case (o_reg.state)
            icc_pkg::ICC_SCL_IDLE: begin
                o_next.scl_oe_n = 1'b1;
                if (o_reg.cfg.run) begin
                    o_next.state = icc_pkg::ICC_SCL_LOW;
                    o_next.cnt = o_reg.cfg.low_period;
                    o_next.scl_oe_n = 1'b0;
                end
            end
            icc_pkg::ICC_SCL_LOW: begin
                if (!o_reg.cfg.run) begin
                    // release the line at once
                    o_next.state = icc_pkg::ICC_SCL_IDLE;
                    o_next.scl_oe_n = 1'b1;
                end else if (o_reg.cnt > 8'h01) begin
                    o_next.cnt = o_reg.cnt - 8'h01;
                end else if (!o_reg.cfg.stretch) begin
                    o_next.state = icc_pkg::ICC_SCL_HIGH;
                    o_next.cnt = o_reg.cfg.high_period;
                    o_next.scl_oe_n = 1'b1;
                end
            end
            icc_pkg::ICC_SCL_HIGH: begin
                o_next.scl_oe_n = 1'b1;
                if (!o_reg.cfg.run) begin
                    o_next.state = icc_pkg::ICC_SCL_IDLE;
                end else if (o_reg.cnt > 8'h01) begin
                    o_next.cnt = o_reg.cnt - 8'h01;
                end else begin
                    o_next.state = icc_pkg::ICC_SCL_LOW;
                    o_next.cnt = o_reg.cfg.low_period;
                    o_next.scl_oe_n = 1'b0;
                end
            end
            default: begin
                o_next.state = icc_pkg::ICC_SCL_IDLE;
                o_next.scl_oe_n = 1'b1;
            end
        endcase
    end

    // oscillator-side flip-flops
    always_ff @(posedge i_osc_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg <= '{req_m: 1'b0, req_s: 1'b0, ack: 1'b0,
                       cfg: '{low_period: `ICC_RST_SCL_LOW, high_period: `ICC_RST_SCL_HIGH,
                              run: 1'b0, stretch: 1'b0},
                       state: icc_pkg::ICC_SCL_IDLE, cnt: 8'h00, scl_oe_n: 1'b1};
        end else begin
            o_reg <= o_next;
        end
    end

    // outputs straight from flip-flops, except o_scl_out which is tied low
    assign o_data = r_reg.rdata;
    assign o_data_oe_n = r_reg.doe_n;
    assign o_int_n = r_reg.int_n;
    assign o_scl_out = 1'b0;
    assign o_scl_oe_n = o_reg.scl_oe_n;
    assign o_buffered_mode = r_reg.mode;
    assign o_byte_count = r_reg.count[6:0];
    assign o_last_byte_nack = r_reg.count[`ICC_LAST_BYTE_BIT];
    assign o_count_bad = r_reg.count_bad;
    assign o_own_match = r_reg.own_match;
    assign o_gc_match = r_reg.gc_match;
    assign o_bus_error = r_reg.bus_err;
    assign o_soft_reset = r_reg.soft_rst;

endmodule // icc_cfg

// *** hdl/icc_defs.svh ***
// constants of the indirect configuration block: offsets, fields, reset values, keys, timings
// assumes inclusion by the top module, the checker and the bench; definitions only
`ifndef ICC_DEFS_SVH
`define ICC_DEFS_SVH

// direct parallel-bus addresses on the two address pins
`define ICC_DIR_PTR_STATUS 2'h0
`define ICC_DIR_DATA 2'h1
`define ICC_DIR_INDIRECT 2'h2
`define ICC_DIR_CONTROL 2'h3

// indirect register numbers selected by the pointer
`define ICC_IND_COUNT 8'h00
`define ICC_IND_OWN_ADDR 8'h01
`define ICC_IND_SCL_LOW 8'h02
`define ICC_IND_SCL_HIGH 8'h03
`define ICC_IND_TIMEOUT 8'h04
`define ICC_IND_RESET_KEY 8'h05

// field positions
`define ICC_LAST_BYTE_BIT 7
`define ICC_GC_BIT 0
`define ICC_TE_BIT 7
`define ICC_MODE_BIT 0
`define ICC_SI_BIT 3

// reset values (scl low and high in clock periods of standard speed)
`define ICC_RST_COUNT 8'h00
`define ICC_RST_OWN_ADDR 8'h00
`define ICC_RST_SCL_LOW 8'h9d
`define ICC_RST_SCL_HIGH 8'h86
`define ICC_RST_TIMEOUT 8'h00
`define ICC_RST_STATUS 8'hf8

// status, limits and reset keys
`define ICC_STATUS_BUS_ERROR 8'h78
`define ICC_MAX_COUNT 7'h44
`define ICC_KEY_FIRST 8'ha5
`define ICC_KEY_SECOND 8'h5a

// time-out unit and reference clock period
`define ICC_TO_UNIT_US 143.36
`define ICC_REF_PERIOD_NS 25.0

`endif

// *** hdl/icc_pkg.sv ***
// types shared by the indirect configuration block
// assumes icc_defs.svh lies on the include path
package icc_pkg;

    // master scl generator states, one-hot
    typedef enum logic [2:0] {
        ICC_SCL_IDLE = 3'b001,
        ICC_SCL_LOW = 3'b010,
        ICC_SCL_HIGH = 3'b100
    } icc_scl_e;

    // word handed from the register side to the oscillator side
    typedef struct packed {
        logic [7:0] low_period;
        logic [7:0] high_period;
        logic run;
        logic stretch;
    } icc_link_s;

    // parallel bus pins after synchronising
    typedef struct packed {
        logic cs_n;
        logic wr_n;
        logic rd_n;
        logic [1:0] addr;
        logic [7:0] data;
    } icc_pbus_s;

endpackage : icc_pkg

// *** test/icc_cfg_assertions.sv ***
// concurrent checks on the ports of the indirect configuration block
// assumes icc_defs.svh on the include path; bound into every icc_cfg instance
`include "icc_defs.svh"
module icc_cfg_assertions (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // inputs watched
    input wire logic i_cs_n,
    input wire logic i_master,
    input wire logic i_addr_valid,
    input wire logic [7:0] i_addr_byte,
    input wire logic i_rx_count_we,
    input wire logic [6:0] i_rx_count,
    // outputs watched
    input wire logic o_data_oe_n,
    input wire logic o_int_n,
    input wire logic o_scl_oe_n,
    input wire logic o_buffered_mode,
    input wire logic [6:0] o_byte_count,
    input wire logic o_count_bad,
    input wire logic o_own_match,
    input wire logic o_gc_match,
    input wire logic o_bus_error,
    input wire logic o_soft_reset
);
    // every check lives in the register clock domain
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    // an address byte offered while the engine is a slave
    sequence s_slave_addr;
        $past(i_addr_valid) && !$past(i_master);
    endsequence
    // a bus error just posted
    sequence s_err_posted;
        $rose(o_bus_error);
    endsequence
    a_own_match_time: assert property (o_own_match |-> s_slave_addr)
        else $error("own match without slave address byte");
    a_gc_match_zero: assert property (o_gc_match |-> s_slave_addr and $past(i_addr_byte[7:1]) == 7'h00)
        else $error("general call match on nonzero byte");
    a_bad_count_cause: assert property (o_count_bad |-> o_buffered_mode &&
        (o_byte_count == 7'h00 || o_byte_count > `ICC_MAX_COUNT))
        else $error("count fault with legal count");
    a_bad_count_int: assert property (o_count_bad |-> ##[0:2] !o_int_n)
        else $error("count fault raised no interrupt");
    a_rx_count_load: assert property (i_rx_count_we |=> o_byte_count == $past(i_rx_count))
        else $error("received count not stored");
    a_err_holds: assert property (o_bus_error && !o_soft_reset |=> o_bus_error)
        else $error("bus error dropped without reset");
    a_err_int_low: assert property (s_err_posted |-> ##[0:2] !o_int_n)
        else $error("bus error raised no interrupt");
    a_err_scl_free: assert property (s_err_posted |-> ##[1:60] o_scl_oe_n)
        else $error("scl not released after bus error");
    a_soft_clears: assert property (o_soft_reset |=> !o_soft_reset && !o_bus_error)
        else $error("software reset not a clean pulse");
    a_data_idle: assert property (i_cs_n [*5] |-> o_data_oe_n)
        else $error("data driven while not selected");
endmodule // icc_cfg_assertions

bind icc_cfg icc_cfg_assertions u_icc_chk (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_master(i_master),
    .i_addr_valid(i_addr_valid), .i_addr_byte(i_addr_byte), .i_rx_count_we(i_rx_count_we),
    .i_rx_count(i_rx_count), .o_data_oe_n(o_data_oe_n), .o_int_n(o_int_n), .o_scl_oe_n(o_scl_oe_n),
    .o_buffered_mode(o_buffered_mode), .o_byte_count(o_byte_count), .o_count_bad(o_count_bad),
    .o_own_match(o_own_match), .o_gc_match(o_gc_match), .o_bus_error(o_bus_error),
    .o_soft_reset(o_soft_reset)
);

// *** test/icc_cfg_tb.sv ***
// self-checking bench of the indirect configuration block
// assumes the design, its header, the checker and the scl bus model are compiled first
`include "icc_defs.svh"
module icc_cfg_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // clocks, reset and bus pins
    logic i_ref_clk = 1'b0, i_osc_clk = 1'b0, i_rst = 1'b1;
    logic i_cs_n = 1'b1, i_wr_n = 1'b1, i_rd_n = 1'b1;
    logic [1:0] i_addr = 2'h0;
    logic [7:0] i_data = 8'h00, i_addr_byte = 8'h00;
    logic i_master = 1'b0, i_start_req = 1'b0, i_addr_valid = 1'b0, i_rx_count_we = 1'b0;
    logic [6:0] i_rx_count = 7'h00;
    logic i_scl, scl_hold = 1'b0;
    // outputs of the block
    logic [7:0] o_data;
    logic [6:0] o_byte_count;
    logic o_data_oe_n, o_int_n, o_scl_out, o_scl_oe_n, o_buffered_mode, o_last_byte_nack;
    logic o_count_bad, o_own_match, o_gc_match, o_bus_error, o_soft_reset;
    // bookkeeping
    int n_mismatch = 0, checks_done = 0, cyc = 0, low_len = 0, last_low = 0;
    logic [7:0] rv, cv;
    logic seen_bad = 0, seen_soft = 0, seen_own = 0, seen_gc = 0;
    logic [6:0] cnt_tab [5] = '{7'h00, 7'h01, 7'h44, 7'h45, 7'h7f};

    always #12.5 i_ref_clk = ~i_ref_clk;
    // link clock, offset so its edges drift against the register clock
    initial begin
        #7;
        forever #80 i_osc_clk = ~i_osc_clk;
    end

    icc_cfg #(.P_TO_UNIT_CYC(4)) dut (
        .i_ref_clk(i_ref_clk), .i_osc_clk(i_osc_clk), .i_rst(i_rst), .i_cs_n(i_cs_n), .i_wr_n(i_wr_n),
        .i_rd_n(i_rd_n), .i_addr(i_addr), .i_data(i_data), .o_data(o_data), .o_data_oe_n(o_data_oe_n),
        .o_int_n(o_int_n), .i_scl(i_scl), .o_scl_out(o_scl_out), .o_scl_oe_n(o_scl_oe_n),
        .i_master(i_master), .i_start_req(i_start_req), .i_addr_valid(i_addr_valid),
        .i_addr_byte(i_addr_byte), .i_rx_count_we(i_rx_count_we), .i_rx_count(i_rx_count),
        .o_buffered_mode(o_buffered_mode), .o_byte_count(o_byte_count), .o_last_byte_nack(o_last_byte_nack),
        .o_count_bad(o_count_bad), .o_own_match(o_own_match), .o_gc_match(o_gc_match),
        .o_bus_error(o_bus_error), .o_soft_reset(o_soft_reset)
    );
    icc_scl_bus u_bus (.i_oe_n(o_scl_oe_n), .i_hold_low(scl_hold), .o_scl(i_scl));

    // sticky records of one-cycle pulses, and the hang limit
    always @(posedge i_ref_clk) begin
        cyc <= cyc + 1;
        if (o_count_bad === 1'b1) seen_bad <= 1'b1;
        if (o_soft_reset === 1'b1) seen_soft <= 1'b1;
        if (o_own_match === 1'b1) seen_own <= 1'b1;
        if (o_gc_match === 1'b1) seen_gc <= 1'b1;
        if (cyc == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    // length of the last scl low phase in link clock cycles
    always @(posedge i_osc_clk) begin
        if (o_scl_oe_n === 1'b0) low_len <= low_len + 1;
        else if (low_len != 0) begin
            last_low <= low_len;
            low_len <= 0;
        end
    end

    function automatic logic bad_exp(input logic [7:0] c);
        return c[6:0] == 7'h00 || c[6:0] > `ICC_MAX_COUNT;
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one write cycle on the pins, strobes held well past the synchronisers
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        {i_cs_n, i_addr, i_data} = {1'b0, a, d};
        repeat (4) @(negedge i_ref_clk);
        i_wr_n = 1'b0;
        repeat (5) @(negedge i_ref_clk);
        i_wr_n = 1'b1;
        repeat (5) @(negedge i_ref_clk);
        i_cs_n = 1'b1;
        repeat (5) @(negedge i_ref_clk);
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(negedge i_ref_clk);
        {i_cs_n, i_rd_n, i_addr} = {2'b00, a};
        repeat (6) @(negedge i_ref_clk);
        d = o_data;
        chk("data_oe_n", 8'h00, 8'(o_data_oe_n));
        {i_cs_n, i_rd_n} = 2'b11;
        repeat (6) @(negedge i_ref_clk);
    endtask
    task automatic iwr(input logic [7:0] p, input logic [7:0] d);
        wr(`ICC_DIR_PTR_STATUS, p);
        wr(`ICC_DIR_INDIRECT, d);
    endtask
    task automatic ird(input logic [7:0] p, input logic [7:0] e, input string nm);
        wr(`ICC_DIR_PTR_STATUS, p);
        rd(`ICC_DIR_INDIRECT, rv);
        chk(nm, e, rv);
    endtask
    task automatic send_addr(input logic [7:0] b, input logic own_e, input logic gc_e);
        @(negedge i_ref_clk);
        {seen_own, seen_gc, i_addr_valid, i_addr_byte} = {3'b001, b};
        @(negedge i_ref_clk);
        i_addr_valid = 1'b0;
        repeat (3) @(negedge i_ref_clk);
        chk("own_match", 8'(own_e), 8'(seen_own));
        chk("gc_match", 8'(gc_e), 8'(seen_gc));
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        void'($urandom(17014));
        repeat (12) @(negedge i_ref_clk);
        i_rst = 1'b0;
        repeat (4) @(negedge i_ref_clk);
        ird(`ICC_IND_COUNT, `ICC_RST_COUNT, "count");
        ird(`ICC_IND_OWN_ADDR, `ICC_RST_OWN_ADDR, "own");
        ird(`ICC_IND_SCL_LOW, `ICC_RST_SCL_LOW, "scl_low");
        ird(`ICC_IND_SCL_HIGH, `ICC_RST_SCL_HIGH, "scl_high");
        ird(`ICC_IND_RESET_KEY, 8'h00, "key");
        ird(8'h07, 8'h00, "unmapped");
        $display("test reset values done");
        for (int i = 1; i < 5; i++) begin
            cv = 8'($urandom) | 8'h02;
            iwr(8'(i), cv);
            ird(8'(i), cv, "readback");
        end
        $display("test readback done");
        wr(`ICC_DIR_CONTROL, 8'h01);
        foreach (cnt_tab[i]) begin
            cv = {1'($urandom), cnt_tab[i]};
            iwr(`ICC_IND_COUNT, cv);
            seen_bad = 1'b0;
            wr(`ICC_DIR_CONTROL, 8'h01);
            chk("count_bad", 8'(bad_exp(cv)), 8'(seen_bad));
            chk("mode", 8'h01, 8'(o_buffered_mode));
            chk("int_n", 8'(!bad_exp(cv)), 8'(o_int_n));
            chk("last_byte", 8'(cv[7]), 8'(o_last_byte_nack));
            chk("byte_count", 8'(cv[6:0]), 8'(o_byte_count));
        end
        @(negedge i_ref_clk);
        {i_rx_count_we, i_rx_count} = {1'b1, 7'($urandom)};
        @(negedge i_ref_clk);
        i_rx_count_we = 1'b0;
        ird(`ICC_IND_COUNT, {cv[7], i_rx_count}, "rx_count");
        wr(`ICC_DIR_CONTROL, 8'h00);
        chk("int_clear", 8'h01, 8'(o_int_n));
        chk("mode_off", 8'h00, 8'(o_buffered_mode));
        $display("test byte count done");
        // time-out off before any master phase, so random periods cannot post a bus error
        iwr(`ICC_IND_TIMEOUT, 8'h00);
        for (int m = 0; m < 4; m++) begin
            cv = {7'($urandom) | 7'h01, m[0]};
            iwr(`ICC_IND_OWN_ADDR, cv);
            i_master = m[1];
            send_addr({cv[7:1], 1'($urandom)}, !m[1], 1'b0);
            send_addr(8'h00, 1'b0, m[0] & !m[1]);
        end
        // stop the generator so a long random low phase cannot hide the new periods
        i_master = 1'b0;
        $display("test address match done");
        iwr(`ICC_IND_SCL_LOW, 8'h03);
        iwr(`ICC_IND_SCL_HIGH, 8'h02);
        i_master = 1'b1;
        repeat (200) @(negedge i_ref_clk);
        chk("scl_low_len", 8'h03, 8'(last_low));
        chk("scl_out", 8'h00, 8'(o_scl_out));
        i_master = 1'b0;
        $display("test scl periods done");
        i_start_req = 1'b1;
        iwr(`ICC_IND_TIMEOUT, 8'h05);
        scl_hold = 1'b1;
        repeat (100) @(negedge i_ref_clk);
        chk("err_disabled", 8'h00, 8'(o_bus_error));
        scl_hold = 1'b0;
        iwr(`ICC_IND_TIMEOUT, 8'h85);
        for (int k = 0; k < 5; k++) begin
            scl_hold = 1'b1;
            repeat (16) @(negedge i_ref_clk);
            scl_hold = 1'b0;
            repeat (4) @(negedge i_ref_clk);
        end
        chk("err_reload", 8'h00, 8'(o_bus_error));
        scl_hold = 1'b1;
        repeat (12) @(negedge i_ref_clk);
        chk("err_early", 8'h00, 8'(o_bus_error));
        repeat (40) @(negedge i_ref_clk);
        chk("err_set", 8'h01, 8'(o_bus_error));
        chk("err_int", 8'h00, 8'(o_int_n));
        chk("scl_free", 8'h01, 8'(o_scl_oe_n));
        scl_hold = 1'b0;
        i_start_req = 1'b0;
        rd(`ICC_DIR_PTR_STATUS, rv);
        chk("status", `ICC_STATUS_BUS_ERROR, rv);
        $display("test time-out done");
        seen_soft = 1'b0;
        iwr(`ICC_IND_RESET_KEY, `ICC_KEY_FIRST);
        wr(`ICC_DIR_INDIRECT, 8'h5b);
        wr(`ICC_DIR_INDIRECT, `ICC_KEY_SECOND);
        iwr(`ICC_IND_RESET_KEY, `ICC_KEY_FIRST);
        iwr(`ICC_IND_RESET_KEY, `ICC_KEY_SECOND);
        chk("no_reset", 8'h00, 8'(seen_soft));
        chk("err_kept", 8'h01, 8'(o_bus_error));
        wr(`ICC_DIR_INDIRECT, `ICC_KEY_FIRST);
        rd(`ICC_DIR_INDIRECT, rv);
        chk("key_read", 8'h00, rv);
        wr(`ICC_DIR_INDIRECT, `ICC_KEY_SECOND);
        chk("soft_reset", 8'h01, 8'(seen_soft));
        chk("err_clear", 8'h00, 8'(o_bus_error));
        ird(`ICC_IND_SCL_LOW, `ICC_RST_SCL_LOW, "scl_low_rst");
        $display("test software reset done");
        print_verdict();
    end
endmodule // icc_cfg_tb

// *** test/icc_scl_bus.sv ***
// scl wire of the serial bus: pull-up, the block and a far-side device
// assumes the bench commands hold_low to keep scl low as a stuck slave would
module icc_scl_bus (
    // open-drain drivers
    input wire logic i_oe_n,
    input wire logic i_hold_low,
    // resolved wire level
    output logic o_scl
);
    timeunit 1ns;
    timeprecision 1ps;
    // wired-and with pull-up: a released line reads high
    assign o_scl = i_oe_n & !i_hold_low;
endmodule // icc_scl_bus
